// ===== common/boost_seq_consts.svh
// Purpose: Timing and encoding constants for the boost mode sequencer.
// Assumes: 100 MHz system clock (10 ns period).
// Notes:   Cycle counts derive from the times.
`ifndef BOOST_SEQ_CONSTS_SVH
`define BOOST_SEQ_CONSTS_SVH

// =====================================================================
// Clock and time base
// =====================================================================
`define CLK_PERIOD_NS        10
`define NS_PER_US            1000
`define NS_PER_MS            1000000

// =====================================================================
// Sequencer timeouts
// =====================================================================
`define LIN_HIGH_TIMEOUT_US  1024
`define SOFTSTART_TIMEOUT_MS 2
`define RESTART_DELAY_MS     1
`define LIN_HIGH_TIMEOUT_CYC ((`LIN_HIGH_TIMEOUT_US * `NS_PER_US) / `CLK_PERIOD_NS)
`define SOFTSTART_TIMEOUT_CYC ((`SOFTSTART_TIMEOUT_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define RESTART_DELAY_CYC    ((`RESTART_DELAY_MS * `NS_PER_MS) / `CLK_PERIOD_NS)

// =====================================================================
// Encodings
// =====================================================================
`define ILIM_1A              2'h1
`define ILIM_2A              2'h2
`define ILIM_NONE            2'h0
`define TARGET_3V30          1'h0
`define TARGET_3V55          1'h1
`define RAMP_WIDTH           8
`define RAMP_STEP_CYC        64
`define RAMP_FULL            8'hFF
`define SYNC_RESET_VAL       3'h0

`endif

// ===== common/boost_seq_pkg.sv
// Purpose: Shared types for the boost mode sequencer.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Numeric constants live in the consts header.
`default_nettype none

package boost_seq_pkg;
   // =====================================================================
   // Sequencer states
   // =====================================================================
   typedef enum logic [3:0] {
      ST_SHUTDOWN,
      ST_WAIT_SUPPLY,
      ST_LIN_LOW,
      ST_LIN_HIGH,
      ST_SOFTSTART,
      ST_BOOST,
      ST_BYPASS,
      ST_FORCED_PASS,
      ST_FAULT
   } seq_state_e;
endpackage

`default_nettype wire

// ===== tb/boost_bypass_mode_sequencer_asserts.sv
// Purpose: Port-level checker for the boost mode sequencer.
// Assumes: Pin filter latency stays under eight cycles.
// Notes:   Bound to every instance of the sequencer.
`timescale 1ns/100ps
`default_nettype none

module boost_seq_asserts #(
   parameter int LIN_HIGH_TIMEOUT_CYC = 50,    // Second linear phase limit.
   parameter int RESTART_DELAY_CYC    = 30     // Fault restart delay.
) (
   input wire logic       clk, sys_rst, enable, force_passthrough_n, // Clock, reset, mode pins.
   input wire logic       output_level_select, input_low_lockout,    // Select and lockout.
   input wire logic       vin_above_target, overcurrent_guard,       // Comparators.
   input wire logic       temp_above_120c,                           // Hot die flag.
   input wire logic       boost_low_switch, boost_high_switch,       // Boost gates.
   input wire logic       bypass_switch, linear_charge_phase_low,    // Bypass and phase.
   input wire logic       linear_charge_phase_high,                  // Second phase.
   input wire logic [1:0] charge_current_limit,                      // Limit code.
   input wire logic [7:0] reference_ramp,                            // Reference.
   input wire logic       target_level, output_discharge,            // Target, discharge.
   input wire logic       supply_ok_out, fault_active                // Power-good, fault.
);
   int hi_n;                                   // Cycles in the second phase.
   int flt_n;                                  // Cycles in fault.

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Run-length counters for the timed states.
   always_ff @(posedge clk) begin
      hi_n <= (sys_rst || !linear_charge_phase_high) ? 0 : hi_n + 1;
      flt_n <= (sys_rst || !fault_active) ? 0 : flt_n + 1;
   end

   // =====================================================================
   // Properties
   // =====================================================================
   chk_shutdown_all_off: assert property (!enable[*8] |-> !boost_low_switch && !boost_high_switch
      && !bypass_switch && output_discharge) else $error("on while off");
   chk_forced_pass: assert property ((enable && !force_passthrough_n && !fault_active
      && !input_low_lockout)[*8] |=> bypass_switch && !boost_low_switch && !boost_high_switch)
      else $error("no forced pass");
   chk_lin_limit: assert property (linear_charge_phase_low || linear_charge_phase_high |->
      charge_current_limit == (linear_charge_phase_high ? 2'h2 : 2'h1)) else $error("bad charge limit");
   chk_lin_timeout: assert property (hi_n <= LIN_HIGH_TIMEOUT_CYC + 2)
      else $error("phase overran");
   chk_fault_off: assert property (fault_active |-> !boost_low_switch && !boost_high_switch
      && !bypass_switch && !supply_ok_out) else $error("switch on in fault");
   chk_restart_gap: assert property ($fell(fault_active) && enable |-> flt_n >= RESTART_DELAY_CYC - 1
      && flt_n <= RESTART_DELAY_CYC + 2) else $error("restart delay wrong");
   chk_supply_ok_out_after_ramp: assert property ($rose(supply_ok_out) |-> reference_ramp == 8'hFF)
      else $error("early power-good");
   chk_hot_supply_ok_out: assert property (temp_above_120c[*8] |-> !supply_ok_out)
      else $error("hot power-good");
   chk_oc_pulse: assert property (overcurrent_guard[*8] |-> !boost_low_switch)
      else $error("pulse in over-current");
   chk_auto_bypass: assert property ((supply_ok_out && vin_above_target && enable
      && force_passthrough_n)[*8] |-> bypass_switch && !boost_low_switch && !boost_high_switch)
      else $error("no automatic bypass");
   chk_target_sel: assert property ((supply_ok_out && $stable(output_level_select))[*8] |->
      target_level == output_level_select) else $error("target level wrong");

   cov_supply_ok_out: cover property ($rose(supply_ok_out));
   cov_fault: cover property ($fell(fault_active));
   cov_forced: cover property (bypass_switch && !force_passthrough_n);
endmodule // boost_seq_asserts

bind boost_bypass_mode_sequencer boost_seq_asserts #(.LIN_HIGH_TIMEOUT_CYC(LIN_HIGH_TIMEOUT_CYC),
   .RESTART_DELAY_CYC(RESTART_DELAY_CYC)) u_chk (.*);

`default_nettype wire

// ===== tb/boost_bypass_mode_sequencer_test.sv
// Purpose: Directed bench for the boost mode sequencer.
// Assumes: Short timeouts; host model keeps the pin order.
// Notes:   Inputs move 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none

module boost_bypass_mode_sequencer_test;
   logic       clk = 1'b0;                     // System clock.
   logic       sys_rst, power_req, auto_req, output_level_select, input_low_lockout, vout_near_vin;
   logic       vout_at_target, vin_above_target, overcurrent_guard, temp_above_120c, temp_below_100c;
   logic       temp_shutdown_hi, temp_shutdown_clr, pwm_pulse_req, enable, force_passthrough_n;
   logic       boost_low_switch, boost_high_switch, bypass_switch, linear_charge_phase_low;
   logic       linear_charge_phase_high, target_level, output_discharge, supply_ok_out, supply_ok_oe;
   logic       fault_active;                   // Fault flag seen.
   logic [1:0] charge_current_limit;           // Limit code seen.
   logic [7:0] reference_ramp;                 // Reference seen.
   int         err_total = 0;                  // Mismatches.
   int         num_checks = 0;                 // Comparisons.
   int         n;                              // Wait counter.

   boost_bypass_mode_sequencer #(.LIN_HIGH_TIMEOUT_CYC(50), .SOFTSTART_TIMEOUT_CYC(400),
      .RESTART_DELAY_CYC(30), .RAMP_STEP_CYC(1)) dut (.*);
   boost_host_model host (.*);

   always #5 clk = ~clk;

   // =====================================================================
   // Helpers
   // =====================================================================
   // Advance whole cycles, then 1 ns.
   task automatic step(int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   // Compare and log a mismatch.
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Print the verdict and stop.
   task automatic finish_test();
      if (err_total == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Cut a hang short.
   initial begin
      #250000;
      err_total++;
      finish_test();
   end

   // =====================================================================
   // Scenarios
   // =====================================================================
   initial begin
      {sys_rst, temp_below_100c, temp_shutdown_clr, pwm_pulse_req} = 4'hF;
      {power_req, auto_req, output_level_select, input_low_lockout, vout_near_vin} = 5'h00;
      {vout_at_target, vin_above_target, overcurrent_guard, temp_above_120c, temp_shutdown_hi} = 5'h00;
      step(2);
      sys_rst = 1'b0;
      step(10);
      check("bypass_off", bypass_switch, 1'b0);
      check("discharge", output_discharge, 1'b1);
      check("supply_ok_out_pull", supply_ok_oe, 1'b1);
      {power_req, auto_req, input_low_lockout} = 3'h7;
      step(100);
      check("forced_bypass", bypass_switch, 1'b1);
      check("forced_noswitch", boost_low_switch, 1'b0);
      check("discharge_off", output_discharge, 1'b0);
      step(6000);
      check("locked_phase", linear_charge_phase_low, 1'b0);
      check("locked_bypass", bypass_switch, 1'b0);
      input_low_lockout = 1'b0;
      step(10);
      check("lin_low", linear_charge_phase_low, 1'b1);
      check("limit_1a", charge_current_limit, 2'h1);
      check("no_switch", boost_low_switch, 1'b0);
      vout_near_vin = 1'b1;
      n = 0;
      while (linear_charge_phase_high !== 1'b1 && n < 20) begin
         step(1);
         n++;
      end
      check("limit_2a", charge_current_limit, 2'h2);
      step(100);
      check("ramp_moving", reference_ramp != 8'h00, 1'b1);
      check("supply_ok_out_early", supply_ok_out, 1'b0);
      vout_at_target = 1'b1;
      step(250);
      check("supply_ok_out_up", supply_ok_out, 1'b1);
      check("ramp_full", reference_ramp, 8'hFF);
      check("boost_pulse", boost_low_switch, 1'b1);
      overcurrent_guard = 1'b1;
      step(10);
      check("oc_hold", boost_low_switch, 1'b0);
      check("oc_rect", boost_high_switch, 1'b1);
      overcurrent_guard = 1'b0;
      step(10);
      check("oc_clear", boost_low_switch, 1'b1);
      {temp_above_120c, temp_below_100c} = 2'h2;
      step(10);
      check("hot_supply_ok_out", supply_ok_out, 1'b0);
      temp_above_120c = 1'b0;
      step(10);
      check("hot_hyst", supply_ok_out, 1'b0);
      temp_below_100c = 1'b1;
      step(10);
      check("cool_supply_ok_out", supply_ok_out, 1'b1);
      {output_level_select, vin_above_target} = 2'h3;
      step(10);
      check("bypass_on", bypass_switch, 1'b1);
      check("bypass_nopulse", boost_low_switch, 1'b0);
      check("sel_bypass", target_level, 1'b1);
      {output_level_select, vin_above_target} = 2'h0;
      step(10);
      check("sel_boost", target_level, 1'b0);
      check("bypass_left", bypass_switch, 1'b0);
      {temp_shutdown_hi, temp_shutdown_clr} = 2'h2;
      step(10);
      temp_shutdown_hi = 1'b0;
      step(10);
      check("otp_latched", boost_low_switch, 1'b0);
      temp_shutdown_clr = 1'b1;
      step(300);
      check("otp_clear", boost_low_switch, 1'b1);
      power_req = 1'b0;
      step(10);
      check("off_discharge", output_discharge, 1'b1);
      check("off_switch", boost_low_switch, 1'b0);
      {power_req, vout_at_target} = 2'h2;
      step(6020);
      n = 0;
      while (fault_active !== 1'b1 && n < 800) begin
         step(1);
         n++;
      end
      check("ss_timeout", fault_active, 1'b1);
      check("fault_bypass", bypass_switch, 1'b0);
      check("fault_supply_ok_out", supply_ok_out, 1'b0);
      n = 0;
      while (fault_active !== 1'b0 && n < 100) begin
         step(1);
         n++;
      end
      check("restart_gap", n >= 28 && n <= 32, 1'b1);
      finish_test();
   end
endmodule // boost_bypass_mode_sequencer_test

`default_nettype wire

// ===== tb/boost_host_model.sv
// Purpose: Host model driving the enable and pass-through pins.
// Assumes: Bench drives power_req and auto_req.
// Notes:   Pass-through stays low for the gap after enable.
`timescale 1ns/100ps
`default_nettype none

module boost_host_model #(
   parameter int PT_WAIT_CYC = 6001            // Gap above 60 us at 100 MHz.
) (
   input  wire logic clk,                      // System clock.
   input  wire logic power_req,                // Bench wants the device on.
   input  wire logic auto_req,                 // Bench wants automatic mode.
   output logic      enable,                   // Enable pin.
   output logic      force_passthrough_n       // Pass-through pin, active low.
);
   int gap_n = 0;                              // Cycles since enable rose.

   // =====================================================================
   // Pin sequencing
   // =====================================================================
   // Pins move 1 ns after the edge; pass-through waits.
   always @(posedge clk) begin
      #1;
      enable = power_req;
      gap_n = power_req ? gap_n + 1 : 0;
      force_passthrough_n = auto_req && (gap_n >= PT_WAIT_CYC);
   end
endmodule // boost_host_model

`default_nettype wire

// ===== verilog/boost_bypass_mode_sequencer.sv
// Purpose: Mode and start-up sequencer of a battery boost regulator with bypass.
// Assumes: Analog comparators give digital levels; 100 MHz clock; sys_rst synchronous.
// Notes:   A low enable, once through the pin filter, resets the sequencer to shutdown.
`timescale 1ns/100ps
`default_nettype none
`include "boost_seq_consts.svh"

module boost_bypass_mode_sequencer
   import boost_seq_pkg::*;
#(
   parameter int LIN_HIGH_TIMEOUT_CYC  = `LIN_HIGH_TIMEOUT_CYC,   // Second linear phase limit.
   parameter int SOFTSTART_TIMEOUT_CYC = `SOFTSTART_TIMEOUT_CYC,  // Soft-start limit.
   parameter int RESTART_DELAY_CYC     = `RESTART_DELAY_CYC,      // Fault restart delay.
   parameter int RAMP_STEP_CYC         = `RAMP_STEP_CYC           // Cycles per reference step.
) (
   input  wire logic                    clk,                      // System clock, 100 MHz.
   input  wire logic                    sys_rst,                  // Synchronous reset, active high.
   input  wire logic                    enable,                   // Device enable pin.
   input  wire logic                    force_passthrough_n,      // Forced pass-through, active low.
   input  wire logic                    output_level_select,      // Output target select pin.
   input  wire logic                    input_low_lockout,        // High while input below lockout.
   input  wire logic                    vout_near_vin,            // Output has charged up to input.
   input  wire logic                    vout_at_target,           // Output reached regulation target.
   input  wire logic                    vin_above_target,         // Input exceeds the output target.
   input  wire logic                    overcurrent_guard,        // Inductor current above limit.
   input  wire logic                    temp_above_120c,          // Die hotter than 120C.
   input  wire logic                    temp_below_100c,          // Die cooler than 100C.
   input  wire logic                    temp_shutdown_hi,         // Over-temperature rising trip.
   input  wire logic                    temp_shutdown_clr,        // Below over-temperature falling trip.
   input  wire logic                    pwm_pulse_req,            // Modulator on-pulse request.
   output logic                         boost_low_switch,         // Boost low-side switch gate.
   output logic                         boost_high_switch,        // Boost high-side switch gate.
   output logic                         bypass_switch,            // Bypass switch gate.
   output logic                         linear_charge_phase_low,  // Linear charge at 1A active.
   output logic                         linear_charge_phase_high, // Linear charge at 2A active.
   output logic [1:0]                   charge_current_limit,     // Selected charge limit code.
   output logic [`RAMP_WIDTH-1:0]       reference_ramp,           // Regulation reference level.
   output logic                         target_level,             // Target code, 3.3V or 3.55V.
   output logic                         output_discharge,         // Output discharge path on.
   output logic                         supply_ok_out,            // Power-good level.
   output logic                         supply_ok_oe,             // Power-good open-drain pull-low.
   output logic                         fault_active              // Sequencer is in fault.
);

   // =====================================================================
   // Input synchronisation
   // =====================================================================
   localparam int NPINS = 13;                      // Number of asynchronous inputs.
   logic [NPINS-1:0] raw_pins;                     // Raw pin vector.
   logic [NPINS-1:0] sync_pins;                    // Synchronised pin vector.
   logic en_s, fpn_s, sel_s, input_low_lockout_s, charged_s, attgt_s, vinhi_s; // Synced levels.
   logic oc_s, t120_s, t100_s, tsd_s, tsdclr_s, pulse_s;

   assign raw_pins = {enable, force_passthrough_n, output_level_select, input_low_lockout,
                      vout_near_vin, vout_at_target, vin_above_target, overcurrent_guard,
                      temp_above_120c, temp_below_100c, temp_shutdown_hi, temp_shutdown_clr,
                      pwm_pulse_req};
   assign {en_s, fpn_s, sel_s, input_low_lockout_s, charged_s, attgt_s, vinhi_s, oc_s,
           t120_s, t100_s, tsd_s, tsdclr_s, pulse_s} = sync_pins;

   // All comparator and pin levels pass the three-stage filter.
   pin_sync #(
      .WIDTH   (NPINS)
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin_in  (raw_pins),
      .pin_out (sync_pins)
   );

   // =====================================================================
   // State and counters
   // =====================================================================
   seq_state_e              state_q, state_d;      // Sequencer state.
   logic [31:0]             timer_q;               // Shared state timer.
   logic [15:0]             step_q;                // Ramp step prescaler.
   logic [`RAMP_WIDTH-1:0]  ramp_q;                // Soft-start reference.
   logic                    otp_latch_q;           // Over-temperature latch.
   logic                    hot_q;                 // Hot-die power-good hold.
   logic                    oc_block_q;            // Pulse suppression active.
   logic                    entering;              // State changes this cycle.
   logic                    disabled;              // Enable low, full reset.

   assign disabled = sys_rst || !en_s;
   assign entering = (state_d != state_q);

   // Timeout expiry test shared by the timed states.
   function automatic logic expired(input logic [31:0] t, input int limit);
      expired = (t >= 32'(limit - 1));
   endfunction

   // Next-state logic.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_SHUTDOWN: begin
            if (!fpn_s) begin
               state_d = ST_FORCED_PASS;
            end else begin
               state_d = ST_WAIT_SUPPLY;
            end
         end
         ST_WAIT_SUPPLY: begin
            if (!fpn_s) begin
               state_d = ST_FORCED_PASS;
            end else if (!input_low_lockout_s) begin
               state_d = ST_LIN_LOW;
            end
         end
         ST_LIN_LOW: begin
            if (!fpn_s) begin
               state_d = ST_FORCED_PASS;
            end else if (charged_s) begin
               state_d = ST_LIN_HIGH;
            end
         end
         ST_LIN_HIGH: begin
            if (!fpn_s) begin
               state_d = ST_FORCED_PASS;
            end else if (expired(timer_q, LIN_HIGH_TIMEOUT_CYC)) begin
               state_d = ST_FAULT;
            end else if (charged_s && input_low_lockout_s == 1'b0) begin
               state_d = ST_SOFTSTART;
            end
         end
         ST_SOFTSTART: begin
            if (!fpn_s) begin
               state_d = ST_FORCED_PASS;
            end else if (expired(timer_q, SOFTSTART_TIMEOUT_CYC)) begin
               state_d = ST_FAULT;
            end else if (attgt_s && ramp_q == `RAMP_FULL) begin
               state_d = vinhi_s ? ST_BYPASS : ST_BOOST;
            end
         end
         ST_BOOST: begin
            if (!fpn_s) begin
               state_d = ST_FORCED_PASS;
            end else if (vinhi_s) begin
               state_d = ST_BYPASS;
            end
         end
         ST_BYPASS: begin
            if (!fpn_s) begin
               state_d = ST_FORCED_PASS;
            end else if (!vinhi_s) begin
               state_d = ST_BOOST;
            end
         end
         ST_FORCED_PASS: begin
            if (fpn_s) begin
               state_d = ST_WAIT_SUPPLY;
            end
         end
         ST_FAULT: begin
            if (expired(timer_q, RESTART_DELAY_CYC)) begin
               state_d = ST_WAIT_SUPPLY;
            end
         end
         default: begin
            state_d = ST_SHUTDOWN;
         end
      endcase
   end

   // State register; enable low forces shutdown at once.
   always_ff @(posedge clk) begin
      if (disabled) begin
         state_q <= ST_SHUTDOWN;
      end else begin
         state_q <= state_d;
      end
   end

   // Timer counts clock cycles, cleared on entry to each state.
   always_ff @(posedge clk) begin
      if (disabled || entering) begin
         timer_q <= 32'h0;
      end else if (timer_q != 32'hFFFFFFFF) begin
         timer_q <= timer_q + 32'h1;
      end
   end

   // =====================================================================
   // Soft-start reference ramp
   // =====================================================================
   // The reference climbs one step per prescaler period while in soft-start.
   always_ff @(posedge clk) begin
      if (disabled || state_q != ST_SOFTSTART) begin
         step_q <= 16'h0;
      end else if (step_q == 16'(RAMP_STEP_CYC - 1)) begin
         step_q <= 16'h0;
      end else begin
         step_q <= step_q + 16'h1;
      end
   end

   // Ramp holds full scale in boost and bypass; zero in the other states outside soft-start.
   always_ff @(posedge clk) begin
      if (disabled) begin
         ramp_q <= `RAMP_WIDTH'h0;
      end else if (state_q == ST_BOOST || state_q == ST_BYPASS) begin
         ramp_q <= `RAMP_FULL;
      end else if (state_q != ST_SOFTSTART) begin
         ramp_q <= `RAMP_WIDTH'h0;
      end else if (step_q == 16'(RAMP_STEP_CYC - 1) && ramp_q != `RAMP_FULL) begin
         ramp_q <= ramp_q + `RAMP_WIDTH'h1;
      end
   end

   // =====================================================================
   // Protection latches
   // =====================================================================
   // Over-temperature latch: set wins over clear.
   always_ff @(posedge clk) begin
      if (disabled) begin
         otp_latch_q <= 1'b0;
      end else if (tsd_s) begin
         otp_latch_q <= 1'b1;
      end else if (tsdclr_s) begin
         otp_latch_q <= 1'b0;
      end
   end

   // Hot-die hysteresis for power-good.
   always_ff @(posedge clk) begin
      if (disabled) begin
         hot_q <= 1'b0;
      end else if (t120_s) begin
         hot_q <= 1'b1;
      end else if (t100_s) begin
         hot_q <= 1'b0;
      end
   end

   // Over-current blocks pulses until one cycle after the current indication clears.
   always_ff @(posedge clk) begin
      if (disabled) begin
         oc_block_q <= 1'b0;
      end else begin
         oc_block_q <= oc_s;
      end
   end

   // =====================================================================
   // Switch and status outputs
   // =====================================================================
   logic regulating;                               // Boost switching allowed.
   logic pulse_ok;                                 // On-pulse permitted.
   assign regulating = (state_q == ST_SOFTSTART || state_q == ST_BOOST) && !otp_latch_q;
   assign pulse_ok   = pulse_s && !oc_block_q && !oc_s;

   // Power switch gates; all off in shutdown and fault.
   always_ff @(posedge clk) begin
      if (disabled) begin
         boost_low_switch  <= 1'b0;
         boost_high_switch <= 1'b0;
         bypass_switch     <= 1'b0;
      end else begin
         boost_low_switch  <= regulating && pulse_ok;
         boost_high_switch <= regulating && !pulse_ok;
         bypass_switch     <= (state_q == ST_BYPASS && !otp_latch_q)
                              || state_q == ST_FORCED_PASS;
      end
   end

   // Linear charge phases and their current limit code.
   always_ff @(posedge clk) begin
      if (disabled) begin
         linear_charge_phase_low  <= 1'b0;
         linear_charge_phase_high <= 1'b0;
         charge_current_limit     <= `ILIM_NONE;
      end else begin
         linear_charge_phase_low  <= (state_q == ST_LIN_LOW);
         linear_charge_phase_high <= (state_q == ST_LIN_HIGH);
         if (state_q == ST_LIN_LOW) begin
            charge_current_limit <= `ILIM_1A;
         end else if (state_q == ST_LIN_HIGH) begin
            charge_current_limit <= `ILIM_2A;
         end else begin
            charge_current_limit <= `ILIM_NONE;
         end
      end
   end

   // Reference, target and discharge.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reference_ramp   <= `RAMP_WIDTH'h0;
         target_level     <= `TARGET_3V30;
         output_discharge <= 1'b1;
      end else begin
         reference_ramp   <= ramp_q;
         target_level     <= sel_s ? `TARGET_3V55 : `TARGET_3V30;
         output_discharge <= !en_s;
      end
   end

   // Power-good and fault flags.
   always_ff @(posedge clk) begin
      if (disabled) begin
         supply_ok_out <= 1'b0;
         supply_ok_oe  <= 1'b1;
         fault_active  <= 1'b0;
      end else begin
         supply_ok_out <= (state_q == ST_BOOST || state_q == ST_BYPASS)
                          && !hot_q && !otp_latch_q && !oc_s;
         supply_ok_oe  <= !((state_q == ST_BOOST || state_q == ST_BYPASS)
                          && !hot_q && !otp_latch_q && !oc_s);
         fault_active  <= (state_q == ST_FAULT);
      end
   end

endmodule // boost_bypass_mode_sequencer

`default_nettype wire

// ===== verilog/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
`include "boost_seq_consts.svh"

module pin_sync #(
   parameter int WIDTH = 1                         // Number of pins synchronised.
) (
   input  wire logic             clk,              // System clock.
   input  wire logic             sys_rst,          // Synchronous reset, active high.
   input  wire logic [WIDTH-1:0] pin_in,           // Raw asynchronous pins.
   output logic      [WIDTH-1:0] pin_out           // Filtered synchronous levels.
);

   // =====================================================================
   // Per-bit synchroniser
   // =====================================================================
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic [2:0] stage_q;                      // Stage 0 is metastable-exposed.
         logic       level_q;                      // Accepted level.

         // Shift the pin through three flops.
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               stage_q <= `SYNC_RESET_VAL;
            end else begin
               stage_q <= {stage_q[1:0], pin_in[g]};
            end
         end

         // Accept a change only once the second and third stages agree.
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               level_q <= 1'b0;
            end else if (stage_q[1] == stage_q[2]) begin
               level_q <= stage_q[2];
            end
         end

         assign pin_out[g] = level_q;
      end
   endgenerate

endmodule // pin_sync

`default_nettype wire
